// file: rtl/gpi_port.sv
/*
 gpio pin interrupt and read: masks, raw and masked status, pin readback.
 assumes: pin_in from the pads (asynchronous), requests one-cycle pulses on mclk.
*/
//
// Contract
// - mask request masks only selected pins
// - unmask request enables only selected pins
// - raw or masked status chosen by select
// - status word bits 7:0, upper zero
// - level read returns pad level, unless a status read comes in the same cycle (status wins)
// - unselected pins read as zero on a level read
// - bit n of selector means pin n
// - per-pin edge or level trigger type
// - clear request removes selected pending events, unless an event is detected in the same cycle (set wins)
`timescale 1ns/1ps
`default_nettype none
module gpi_port
    import gpi_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  pin_in,
    input  wire logic [7:0]  pin_select_vector,
    input  wire logic        pin_irq_mask_request,
    input  wire logic        pin_irq_unmask_request,
    input  wire logic        pin_irq_clear_request,
    input  wire logic        pin_irq_type_request,
    input  wire logic [2:0]  trig_type,
    input  wire logic        pin_irq_status_read,
    input  wire logic        status_view_select,
    input  wire logic        pin_level_read,
    output logic [31:0]      read_data,
    output logic             read_valid,
    output logic             port_irq
);
    gpi_det_if det_bus ();

    logic [7:0]  pin_meta;
    logic [7:0]  pin_sync;
    logic [7:0]  irq_enable;
    logic [7:0]  raw_status;
    logic [23:0] trig_cfg;
    logic [7:0]  next_irq_enable;
    logic [7:0]  next_raw_status;
    logic [23:0] next_trig_cfg;
    logic [31:0] next_read_data;
    logic        next_read_valid;
    logic        next_port_irq;
    logic [7:0]  masked_status;

    // two flops before any logic sees the pads
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pin_meta <= RAW_RESET;
            pin_sync <= RAW_RESET;
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    assign det_bus.level = pin_sync;
    assign det_bus.trig  = trig_cfg;

    gpi_detect u_detect (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .det     (det_bus)
    );

    assign masked_status = raw_status & irq_enable;

    always_comb begin
        next_irq_enable = irq_enable;
        next_trig_cfg   = trig_cfg;
        // mask and unmask in one cycle: unmask wins, last write style
        if (pin_irq_mask_request) begin
            next_irq_enable = next_irq_enable & ~pin_select_vector;
        end
        if (pin_irq_unmask_request) begin
            next_irq_enable = next_irq_enable | pin_select_vector;
        end
        for (int i = 0; i < 8; i++) begin
            if (pin_irq_type_request && pin_select_vector[i]) begin
                next_trig_cfg[3*i +: 3] = trig_type;
            end
        end
        // set beats clear; level types re-set while active
        next_raw_status = raw_status;
        if (pin_irq_clear_request) begin
            next_raw_status = next_raw_status & ~pin_select_vector;
        end
        next_raw_status = next_raw_status | det_bus.event_hit;
        next_port_irq   = |(next_raw_status & next_irq_enable);
        next_read_valid = pin_irq_status_read | pin_level_read;
        next_read_data  = WORD_RESET;
        if (pin_irq_status_read) begin
            next_read_data = gpi_word(status_view_select ? masked_status : raw_status);
        end else if (pin_level_read) begin
            next_read_data = gpi_word(pin_sync & pin_select_vector);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            irq_enable <= MASK_RESET;
            raw_status <= RAW_RESET;
            trig_cfg   <= {8{TYPE_RESET}};
            read_data  <= WORD_RESET;
            read_valid <= 1'b0;
            port_irq   <= 1'b0;
        end else begin
            irq_enable <= next_irq_enable;
            raw_status <= next_raw_status;
            trig_cfg   <= next_trig_cfg;
            read_data  <= next_read_data;
            read_valid <= next_read_valid;
            port_irq   <= next_port_irq;
        end
    end

    // pins whose loaded trigger type is code; read by the checks only
    function automatic logic [7:0] pins_of_type(input logic [23:0] cfg, input logic [2:0] code);
        for (int i = 0; i < 8; i++) begin
            pins_of_type[i] = (cfg[3*i +: 3] == code);
        end
    endfunction

    sequence unmask_s;
        pin_irq_unmask_request && !pin_irq_mask_request;
    endsequence

    sequence both_req_s;
        pin_irq_mask_request && pin_irq_unmask_request;
    endsequence

    sequence read_req_s;
        pin_irq_status_read || pin_level_read;
    endsequence

    // edge checks skip the cycle after reset: detector memory restarts at zero
    sequence fall_s;
        !$past(sys_rst) && |($past(pin_sync) & ~pin_sync & pins_of_type(trig_cfg, GPI_FALLING));
    endsequence

    sequence rise_s;
        !$past(sys_rst) && |(~$past(pin_sync) & pin_sync & pins_of_type(trig_cfg, GPI_RISING));
    endsequence

    sequence both_s;
        !$past(sys_rst) && |(($past(pin_sync) ^ pin_sync) & pins_of_type(trig_cfg, GPI_BOTH));
    endsequence

    sequence low_s;
        |(~pin_sync & pins_of_type(trig_cfg, GPI_LOW));
    endsequence

    sequence high_s;
        |(pin_sync & pins_of_type(trig_cfg, GPI_HIGH));
    endsequence

    mask_clears_a: assert property (@(posedge mclk) disable iff (sys_rst)
        pin_irq_mask_request && !pin_irq_unmask_request |=> (irq_enable & $past(pin_select_vector)) == 8'h00)
        else $error("masked pin still enabled");
    mask_keeps_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (pin_irq_mask_request || pin_irq_unmask_request) |=>
        ((irq_enable ^ $past(irq_enable)) & ~$past(pin_select_vector)) == 8'h00)
        else $error("unselected mask changed");
    unmask_sets_a: assert property (@(posedge mclk) disable iff (sys_rst)
        unmask_s |=> (irq_enable & $past(pin_select_vector)) == $past(pin_select_vector))
        else $error("unmask failed");
    both_req_a: assert property (@(posedge mclk) disable iff (sys_rst)
        both_req_s |=> (irq_enable & $past(pin_select_vector)) == $past(pin_select_vector))
        else $error("unmask lost to mask");
    status_view_a: assert property (@(posedge mclk) disable iff (sys_rst)
        pin_irq_status_read |=> read_valid && read_data ==
        {24'h00_0000, $past(status_view_select) ? $past(raw_status & irq_enable) : $past(raw_status)})
        else $error("status word wrong");
    masked_sub_a: assert property (@(posedge mclk) disable iff (sys_rst)
        pin_irq_status_read && status_view_select |=> (read_data[7:0] & ~$past(irq_enable)) == 8'h00)
        else $error("masked view shows disabled pin");
    read_valid_a: assert property (@(posedge mclk) disable iff (sys_rst)
        read_req_s |=> read_valid)
        else $error("read not answered");
    read_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !pin_irq_status_read && !pin_level_read |=> !read_valid && read_data == WORD_RESET)
        else $error("read word outside a read");
    level_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
        pin_level_read && !pin_irq_status_read |=> read_data == {24'h00_0000, $past(pin_in, 3) & $past(pin_select_vector)})
        else $error("level read wrong");
    level_unsel_a: assert property (@(posedge mclk) disable iff (sys_rst)
        pin_level_read && !pin_irq_status_read |=> (read_data[7:0] & ~$past(pin_select_vector)) == 8'h00)
        else $error("unselected pin read as one");
    upper_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
        read_data[31:8] == 24'h00_0000)
        else $error("upper bits set");
    clear_pend_a: assert property (@(posedge mclk) disable iff (sys_rst)
        pin_irq_clear_request |=> ((raw_status & $past(pin_select_vector)) == ($past(det_bus.event_hit) & $past(pin_select_vector))))
        else $error("clear failed");
    irq_out_a: assert property (@(posedge mclk) disable iff (sys_rst)
        ##1 port_irq == |(raw_status & irq_enable))
        else $error("irq mismatch");
    edge_sticky_a: assert property (@(posedge mclk) disable iff (sys_rst)
        |(raw_status & ~$past(raw_status)) && !pin_irq_clear_request |=> (raw_status & $past(raw_status)) == $past(raw_status))
        else $error("raw bit dropped");

    fall_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
        fall_s |=> (~raw_status & $past(pin_sync, 2) & ~$past(pin_sync)
                    & $past(pins_of_type(trig_cfg, GPI_FALLING))) == 8'h00)
        else $error("falling edge lost");
    rise_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
        rise_s |=> (~raw_status & ~$past(pin_sync, 2) & $past(pin_sync)
                    & $past(pins_of_type(trig_cfg, GPI_RISING))) == 8'h00)
        else $error("rising edge lost");
    both_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
        both_s |=> (~raw_status & ($past(pin_sync, 2) ^ $past(pin_sync))
                    & $past(pins_of_type(trig_cfg, GPI_BOTH))) == 8'h00)
        else $error("toggle lost");
    low_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
        low_s |=> (~raw_status & ~$past(pin_sync) & $past(pins_of_type(trig_cfg, GPI_LOW))) == 8'h00)
        else $error("low level lost");
    high_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
        high_s |=> (~raw_status & $past(pin_sync) & $past(pins_of_type(trig_cfg, GPI_HIGH))) == 8'h00)
        else $error("high level lost");
    // a pending bit may only appear from a detected event, so dead codes stay quiet
    no_stray_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (raw_status & ~$past(raw_status) & ~$past(det_bus.event_hit)) == 8'h00)
        else $error("raw bit set without event");
    reset_clear_a: assert property (@(posedge mclk)
        sys_rst |=> !port_irq && !read_valid && read_data == WORD_RESET
        && irq_enable == MASK_RESET && raw_status == RAW_RESET)
        else $error("state not cleared by reset");
endmodule
`default_nettype wire

// file: rtl/gpi_pkg.sv
/*
 gpio pin interrupt and read: shared constants and types.
 assumes: included before every other design file.
*/
`default_nettype none
package gpi_pkg;
    localparam int unsigned PIN_COUNT   = 8;
    localparam int unsigned WORD_WIDTH  = 32;
    localparam logic [7:0]  MASK_RESET  = 8'h00;
    localparam logic [7:0]  RAW_RESET   = 8'h00;
    localparam logic [2:0]  TYPE_RESET  = 3'h0;
    localparam logic [31:0] WORD_RESET  = 32'h0000_0000;

    typedef enum logic [2:0] {
        GPI_FALLING,
        GPI_RISING,
        GPI_BOTH,
        GPI_LOW,
        GPI_HIGH
    } gpi_trig_t;

    typedef enum {
        GPI_ST_IDLE,
        GPI_ST_STATUS,
        GPI_ST_LEVEL
    } gpi_rd_t;

    // place a byte in the low bits of a word, upper bits zero
    function automatic logic [31:0] gpi_word(input logic [7:0] b);
        gpi_word = {24'h00_0000, b};
    endfunction
endpackage
`default_nettype wire

// file: rtl/gpi_det_if.sv
/*
 gpio pin interrupt and read: carrier between the top and the detector.
 assumes: both ends run on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
interface gpi_det_if;
    logic [7:0]  level;
    logic [23:0] trig;
    logic [7:0]  event_hit;
    modport top (output level, output trig, input event_hit);
    modport det (input level, input trig, output event_hit);
endinterface
`default_nettype wire

// file: rtl/gpi_detect.sv
/*
 gpio pin interrupt and read: per-pin edge or level event detector.
 assumes: level already synchronised to mclk by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module gpi_detect
    import gpi_pkg::*;
(
    input  wire logic mclk,
    input  wire logic sys_rst,
    gpi_det_if.det    det
);
    logic [7:0] prev;
    logic [7:0] next_prev;
    logic [7:0] hit;

    always_comb begin
        next_prev = det.level;
        for (int i = 0; i < 8; i++) begin
            case (gpi_trig_t'(det.trig[3*i +: 3]))
                GPI_FALLING: hit[i] = prev[i] & ~det.level[i];
                GPI_RISING:  hit[i] = ~prev[i] & det.level[i];
                GPI_BOTH:    hit[i] = prev[i] ^ det.level[i];
                GPI_LOW:     hit[i] = ~det.level[i];
                GPI_HIGH:    hit[i] = det.level[i];
                default:     hit[i] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prev <= RAW_RESET;
        end else begin
            prev <= next_prev;
        end
    end

    assign det.event_hit = hit;
endmodule
`default_nettype wire

// file: bench/testbench.sv
/*
 gpio pin interrupt and read: self-checking bench for gpi_port.
 assumes: gpi_pkg compiled first; one mclk domain, inputs driven on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import gpi_pkg::*;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  pin_in = 8'h00;
    logic [7:0]  sel = 8'h00;
    logic        msk = 1'b0, unm = 1'b0, clr = 1'b0, typ = 1'b0;
    logic        st_rd = 1'b0, view = 1'b0, lv_rd = 1'b0;
    logic [2:0]  trig_type = 3'h0;
    logic [31:0] read_data;
    logic        read_valid;
    logic        port_irq;
    int          error_cnt = 0;
    int          total_checks = 0;
    int          cycles = 0;

    always #20 mclk = ~mclk;

    gpi_port i_dut (.mclk(mclk), .sys_rst(sys_rst), .pin_in(pin_in), .pin_select_vector(sel),
        .pin_irq_mask_request(msk), .pin_irq_unmask_request(unm), .pin_irq_clear_request(clr),
        .pin_irq_type_request(typ), .trig_type(trig_type), .pin_irq_status_read(st_rd),
        .status_view_select(view), .pin_level_read(lv_rd), .read_data(read_data),
        .read_valid(read_valid), .port_irq(port_irq));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // kind: 0 mask, 1 unmask, 2 clear, 3 type load
    task automatic pulse(input int kind, input logic [7:0] s, input logic [2:0] t);
        @(negedge mclk);
        sel = s;
        trig_type = t;
        case (kind)
            0: msk = 1'b1;
            1: unm = 1'b1;
            2: clr = 1'b1;
            default: typ = 1'b1;
        endcase
        @(negedge mclk);
        {msk, unm, clr, typ} = 4'h0;
    endtask

    // answer stands one cycle, so it is sampled at the very next falling edge
    task automatic rd(input logic st, input logic v, input logic [7:0] s, input logic [31:0] exp);
        @(negedge mclk);
        sel = s;
        view = v;
        st_rd = st;
        lv_rd = ~st;
        @(negedge mclk);
        check({31'h0, read_valid}, 32'h1);
        check(read_data, exp);
        st_rd = 1'b0;
        lv_rd = 1'b0;
    endtask

    // two sync flops plus the detector edge, with margin
    task automatic settle(input logic [7:0] p);
        pin_in = p;
        repeat (5) @(negedge mclk);
    endtask

    task automatic test_level_read;
        settle(8'h3c);
        rd(1'b0, 1'b0, 8'ha5, 32'h24);
        rd(1'b0, 1'b0, 8'hff, 32'h3c);
        settle(8'h00);
        rd(1'b1, 1'b0, 8'h00, 32'h3c);
        rd(1'b1, 1'b1, 8'h00, 32'h00);
        check({31'h0, port_irq}, 32'h0);
        pulse(2, 8'hff, 3'h0);
        rd(1'b1, 1'b0, 8'h00, 32'h00);
        $display("test_level_read done");
    endtask

    task automatic test_edge_mask;
        pulse(3, 8'hff, GPI_RISING);
        settle(8'h24);
        rd(1'b1, 1'b0, 8'h00, 32'h24);
        pulse(1, 8'h24, 3'h0);
        rd(1'b1, 1'b1, 8'h00, 32'h24);
        check({31'h0, port_irq}, 32'h1);
        settle(8'h00);
        rd(1'b1, 1'b0, 8'h00, 32'h24);
        pulse(0, 8'h04, 3'h0);
        rd(1'b1, 1'b1, 8'h00, 32'h20);
        pulse(2, 8'h20, 3'h0);
        rd(1'b1, 1'b0, 8'h00, 32'h04);
        check({31'h0, port_irq}, 32'h0);
        $display("test_edge_mask done");
    endtask

    task automatic test_trig_types;
        pulse(3, 8'h01, GPI_HIGH);
        settle(8'h01);
        pulse(2, 8'h01, 3'h0);
        rd(1'b1, 1'b0, 8'h00, 32'h05);
        settle(8'h00);
        pulse(2, 8'h01, 3'h0);
        pulse(3, 8'h02, GPI_LOW);
        pulse(3, 8'h40, GPI_BOTH);
        settle(8'h40);
        rd(1'b1, 1'b0, 8'h00, 32'h46);
        pulse(2, 8'h40, 3'h0);
        settle(8'h00);
        rd(1'b1, 1'b0, 8'h00, 32'h46);
        $display("test_trig_types done");
    endtask

    // same-cycle mask and unmask, status beating level read, an unused code (5) that never triggers
    task automatic test_corner;
        @(negedge mclk);
        sel = 8'h42;
        {msk, unm} = 2'b11;
        @(negedge mclk);
        {msk, unm} = 2'b00;
        rd(1'b1, 1'b1, 8'h00, 32'h42);
        check({31'h0, port_irq}, 32'h1);
        @(negedge mclk);
        sel = 8'hff;
        view = 1'b0;
        {st_rd, lv_rd} = 2'b11;
        @(negedge mclk);
        {st_rd, lv_rd} = 2'b00;
        check({31'h0, read_valid}, 32'h1);
        check(read_data, 32'h46);
        @(negedge mclk);
        check({31'h0, read_valid}, 32'h0);
        check(read_data, 32'h0);
        pulse(3, 8'h80, 3'h5);
        settle(8'h80);
        rd(1'b0, 1'b0, 8'h81, 32'h80);
        settle(8'h00);
        rd(1'b1, 1'b0, 8'h00, 32'h46);
        $display("test_corner done");
    endtask

    // reset in mid-run drops masks, pending bits and trigger types
    task automatic test_mid_reset;
        check({31'h0, port_irq}, 32'h1);
        @(negedge mclk);
        sys_rst = 1'b1;
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        check({31'h0, port_irq}, 32'h0);
        check(read_data, 32'h0);
        rd(1'b1, 1'b0, 8'h00, 32'h00);
        settle(8'h02);
        rd(1'b1, 1'b0, 8'h00, 32'h00);
        settle(8'h00);
        rd(1'b1, 1'b0, 8'h00, 32'h02);
        rd(1'b1, 1'b1, 8'h00, 32'h00);
        check({31'h0, port_irq}, 32'h0);
        $display("test_mid_reset done");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // whole run is under two hundred cycles; ceiling well clear of it
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        sys_rst = 1'b0;
        test_level_read();
        test_edge_mask();
        test_trig_types();
        test_corner();
        test_mid_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
